/* File: include/ftc_pkg.sv */
// Package of register map constants for the fan fan_speed_pulse_input configuration bank
package ftc_pkg;
  localparam logic [7:0] FTC_ADDR_PULSE = 8'h7b;
  localparam logic [7:0] FTC_ADDR_CFG4 = 8'h7d;
  localparam logic [7:0] FTC_ADDR_TEST1 = 8'h7e;
  localparam logic [7:0] FTC_ADDR_TEST2 = 8'h7f;
  localparam logic [7:0] FTC_RST_PULSE = 8'h55;
  localparam logic [7:0] FTC_RST_CFG4 = 8'h00;
  localparam logic [7:0] FTC_RST_TEST = 8'h00;
  localparam logic [7:0] FTC_CFG4_WMASK = 8'h0d;
  localparam int FTC_ALERT_SEL_BIT = 0;
  localparam int FTC_THR_LSB = 2;
  localparam int FTC_FAN_COUNT = 4;
  localparam logic [7:0] FTC_THR_MV_00 = 8'h14;
  localparam logic [7:0] FTC_THR_MV_01 = 8'h28;
  localparam logic [7:0] FTC_THR_MV_10 = 8'h50;
  localparam logic [7:0] FTC_THR_MV_11 = 8'h82;
  typedef enum logic [1:0] {
    FTC_THR_20MV,
    FTC_THR_40MV,
    FTC_THR_80MV,
    FTC_THR_130MV
  } ftc_thr_t;
endpackage : ftc_pkg

/* File: include/ftc_bus_if.sv */
// Interface carrying register access strobes between bank and decoder
`timescale 1ns/1ps
interface ftc_bus_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic sel_pulse;
  logic sel_cfg4;
  logic sel_test;
  modport dec (input addr, output sel_pulse, output sel_cfg4, output sel_test);
  modport bank (input wr_en, input addr, input wdata, input sel_pulse, input sel_cfg4,
                input sel_test);
endinterface : ftc_bus_if

/* File: rtl/ftc_addr_dec.sv */
// Address decoder for the fan fan_speed_pulse_input configuration bank
`timescale 1ns/1ps
module ftc_addr_dec (
  ftc_bus_if.dec bus
);
  import ftc_pkg::*;
  assign bus.sel_pulse = (bus.addr == FTC_ADDR_PULSE);
  assign bus.sel_cfg4 = (bus.addr == FTC_ADDR_CFG4);
  assign bus.sel_test = (bus.addr == FTC_ADDR_TEST1) || (bus.addr == FTC_ADDR_TEST2);
endmodule : ftc_addr_dec

/* File: rtl/ftc_regs.sv */
// Fan pulse count, alert pin and fan_speed_pulse_input threshold configuration registers
//
// Overview of operation
// - Four two-bit pulse-count fields, fans one to four at bits 1:0 up to 7:6.
// - Each field code 00..11 means counting one to four fan_speed_pulse_input pulses.
// - Pulse-count register resets to 0x55, two pulses per fan.
// - Alert-select bit one turns shared pin into alert output.
// - Alert-select bit zero keeps shared pin as 2.5 V measurement input.
// - Threshold bits 3:2 pick 20, 40, 80 or 130 mV.
// - When lock is set, writes to configuration register four are ignored.
// - Bit 1 and bits 7:4 of configuration four are reserved.
`timescale 1ns/1ps
module ftc_regs (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register access port
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // Lock bit from configuration register one
  input wire logic lock_i,
  // Per-fan pulse targets, 1 to 4
  output logic [2:0] first_fan_pulse_count_o,
  output logic [2:0] second_fan_pulse_count_o,
  output logic [2:0] third_fan_pulse_count_o,
  output logic [2:0] fourth_fan_pulse_count_o,
  // Shared pin mode
  output logic alert_pin_select_o,
  output logic meas_2v5_enable_o,
  // Fan_speed_pulse_input threshold
  output ftc_pkg::ftc_thr_t two_wire_fan_speed_pulse_input_threshold_o,
  output logic [7:0] fan_speed_pulse_input_threshold_mv_o
);
  import ftc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  ftc_bus_if bus ();
  assign bus.wr_en = wr_en_i;
  assign bus.addr = addr_i;
  assign bus.wdata = wdata_i;

  ftc_addr_dec u_dec (
    .bus(bus)
  );

  function automatic logic [2:0] pulses_of(input logic [1:0] code);
    pulses_of = {1'b0, code} + 3'h1;
  endfunction : pulses_of

  function automatic logic [7:0] mv_of(input logic [1:0] code);
    unique case (code)
      2'h0: mv_of = FTC_THR_MV_00;
      2'h1: mv_of = FTC_THR_MV_01;
      2'h2: mv_of = FTC_THR_MV_10;
      2'h3: mv_of = FTC_THR_MV_11;
    endcase
  endfunction : mv_of

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] pulse_r;
  logic [7:0] pulse_nxt;
  logic [7:0] cfg4_r;
  logic [7:0] cfg4_nxt;
  logic [7:0] rdata_nxt;
  wire pulse_we = bus.wr_en && bus.sel_pulse;
  wire cfg4_we = bus.wr_en && bus.sel_cfg4 && !lock_i;

  assign pulse_nxt = pulse_we ? wdata_i : pulse_r;
  assign cfg4_nxt = cfg4_we ? (wdata_i & FTC_CFG4_WMASK) : cfg4_r;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pulse_r <= FTC_RST_PULSE;
      cfg4_r <= FTC_RST_CFG4;
    end else begin
      pulse_r <= pulse_nxt;
      cfg4_r <= cfg4_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback; test registers and unmapped offsets read zero
  assign rdata_nxt = bus.sel_pulse ? pulse_r :
                     bus.sel_cfg4 ? cfg4_r :
                     bus.sel_test ? FTC_RST_TEST : 8'h00;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o <= rd_en_i ? rdata_nxt : rdata_o;
      rvalid_o <= rd_en_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded configuration outputs, registered
  logic [2:0] pulses_nxt [FTC_FAN_COUNT];
  logic [2:0] pulses_r [FTC_FAN_COUNT];

  genvar g;
  generate
    for (g = 0; g < FTC_FAN_COUNT; g++) begin : g_fan
      assign pulses_nxt[g] = pulses_of(pulse_nxt[2*g+1 -: 2]);
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          pulses_r[g] <= 3'h2;
        end else begin
          pulses_r[g] <= pulses_nxt[g];
        end
      end
    end
  endgenerate

  assign first_fan_pulse_count_o = pulses_r[0];
  assign second_fan_pulse_count_o = pulses_r[1];
  assign third_fan_pulse_count_o = pulses_r[2];
  assign fourth_fan_pulse_count_o = pulses_r[3];

  wire [1:0] thr_code = cfg4_nxt[FTC_THR_LSB+1:FTC_THR_LSB];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      alert_pin_select_o <= 1'b0;
      meas_2v5_enable_o <= 1'b1;
      two_wire_fan_speed_pulse_input_threshold_o <= FTC_THR_20MV;
      fan_speed_pulse_input_threshold_mv_o <= FTC_THR_MV_00;
    end else begin
      alert_pin_select_o <= cfg4_nxt[FTC_ALERT_SEL_BIT];
      meas_2v5_enable_o <= !cfg4_nxt[FTC_ALERT_SEL_BIT];
      two_wire_fan_speed_pulse_input_threshold_o <= ftc_thr_t'(thr_code);
      fan_speed_pulse_input_threshold_mv_o <= mv_of(thr_code);
    end
  end
endmodule : ftc_regs

/* File: sim/ftc_asserts.sv */
// Checker for the fan fan_speed_pulse_input config bank
`timescale 1ns/1ps
module ftc_asserts import ftc_pkg::*; (
  input wire logic clock_i, rst_i, wr_en_i, rd_en_i, lock_i, alert_pin_select_o,
  input wire logic meas_2v5_enable_o,
  input wire logic [7:0] addr_i, wdata_i, rdata_o, fan_speed_pulse_input_threshold_mv_o,
  input wire logic [2:0] fourth_fan_pulse_count_o,
  input wire ftc_pkg::ftc_thr_t two_wire_fan_speed_pulse_input_threshold_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_fan_code: assert property (wr_en_i && addr_i == 8'h7b |=>
    fourth_fan_pulse_count_o == 3'($past(wdata_i[7:6])) + 3'h1) else $error("count");
  a_rst_code: assert property ($past(rst_i) |-> fourth_fan_pulse_count_o == 3'h2)
    else $error("reset");
  a_alert_set: assert property (wr_en_i && addr_i == 8'h7d && !lock_i |=>
    alert_pin_select_o == $past(wdata_i[0])) else $error("alert");
  a_meas_mode: assert property (meas_2v5_enable_o ^ alert_pin_select_o) else $error("mode");
  a_thr_mv: assert property (fan_speed_pulse_input_threshold_mv_o == (&two_wire_fan_speed_pulse_input_threshold_o ?
    8'h82 : 8'h14 << two_wire_fan_speed_pulse_input_threshold_o)) else $error("mv");
  a_lock_hold: assert property (wr_en_i && addr_i == 8'h7d && lock_i |=>
    $stable(two_wire_fan_speed_pulse_input_threshold_o)) else $error("lock");
  a_test_zero: assert property (rd_en_i && addr_i > 8'h7d |=> rdata_o == 8'h00)
    else $error("test");
  a_resv_zero: assert property (rd_en_i && addr_i == 8'h7d |=>
    (rdata_o & 8'hf2) == 8'h00) else $error("resv");
endmodule : ftc_asserts
bind ftc_regs ftc_asserts u_chk (.*);

/* File: sim/ftc_host.sv */
// Host model for register access
`timescale 1ns/1ps
module ftc_host (
  input wire logic clock_i,
  output logic wr_en_o, rd_en_o,
  output logic [7:0] addr_o, wdata_o
);
  logic [7:0] exp_q [$];
  initial {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h0;
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_i);
    {wr_en_o, addr_o, wdata_o} <= {1'b1, a, d};
    @(posedge clock_i);
    {wr_en_o, wdata_o} <= {1'b0, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge clock_i);
    {rd_en_o, addr_o} <= {1'b1, a};
    exp_q.push_back(e);
    @(posedge clock_i);
    rd_en_o <= 1'b0;
  endtask : rd
endmodule : ftc_host

/* File: sim/testbench.sv */
// Bench for the fan fan_speed_pulse_input config bank
`timescale 1ns/1ps
module testbench;
  import ftc_pkg::*;
  logic clock_i = 1'b0, rst_i = 1'b1, lock_i = 1'b0, wr_en_i, rd_en_i, rvalid_o;
  logic alert_pin_select_o, meas_2v5_enable_o;
  logic [7:0] addr_i, wdata_i, rdata_o, fan_speed_pulse_input_threshold_mv_o, d;
  logic [2:0] first_fan_pulse_count_o, second_fan_pulse_count_o, third_fan_pulse_count_o;
  logic [2:0] fourth_fan_pulse_count_o;
  ftc_thr_t two_wire_fan_speed_pulse_input_threshold_o;
  int n_fail = 0, cmp_count = 0;
  always #20 clock_i = ~clock_i;
  ftc_host u_host (.clock_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  ftc_regs u_dut (.*);
  task automatic cmp(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %h %h", $time, got, exp);
    end
  endtask : cmp
  task automatic print_verdict;
    $display("compares %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  always @(negedge clock_i) if (rvalid_o === 1'b1) cmp(rdata_o, u_host.exp_q.pop_front());
  initial begin
    #40us;
    n_fail++;
    print_verdict();
  end
  initial begin
    void'($urandom(72392));
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    u_host.rd(8'h7b, 8'h55);
    for (int i = 0; i < 4; i++) begin
      d = {2'(i), 2'(i + 1), 2'(i + 2), 2'(i + 3)};
      u_host.wr(8'h7b, d);
      u_host.rd(8'h7b, d);
      cmp(8'(first_fan_pulse_count_o), 8'(d[1:0]) + 8'h1);
      cmp(8'(second_fan_pulse_count_o), 8'(d[3:2]) + 8'h1);
      cmp(8'(third_fan_pulse_count_o), 8'(d[5:4]) + 8'h1);
      cmp(8'(fourth_fan_pulse_count_o), 8'(d[7:6]) + 8'h1);
      d = {4'($urandom), 2'(i), 2'($urandom)};
      u_host.wr(8'h7d, d);
      u_host.rd(8'h7d, d & 8'h0d);
      cmp(8'(alert_pin_select_o), 8'(d[0]));
      cmp(8'(meas_2v5_enable_o), 8'(!d[0]));
      cmp(8'(two_wire_fan_speed_pulse_input_threshold_o), 8'(d[3:2]));
    end
    lock_i <= 1'b1;
    u_host.wr(8'h7d, ~d);
    u_host.rd(8'h7d, d & 8'h0d);
    lock_i <= 1'b0;
    u_host.wr(8'h7e, 8'hff);
    u_host.rd(8'h7e, 8'h00);
    repeat (2) @(posedge clock_i);
    print_verdict();
  end
endmodule : testbench
